// file: rtl/fwsr_poller.sv
/*
 * host-side status poller for a parallel nor flash: issues command
 * writes, then watches program or erase progress by polling or toggle.
 * assumes flash pins synchronous to clk_in; register port is one-cycle.
 */
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module fwsr_poller (
    input  wire logic                            clk_in,
    input  wire logic                            arst_n_in,
    input  wire logic [fwsr_pkg::REG_ADDR_W-1:0] reg_addr_in,
    input  wire logic [fwsr_pkg::REG_DATA_W-1:0] reg_wdata_in,
    input  wire logic                            reg_wr_in,
    input  wire logic                            reg_rd_in,
    output logic [fwsr_pkg::REG_DATA_W-1:0]      reg_rdata_out,
    input  wire logic [fwsr_pkg::FL_DATA_W-1:0]  dq_in,
    input  wire logic                            ready_busy_n_in,
    output fwsr_pkg::fwsr_pins_t                 flash_out
);
    import fwsr_pkg::*;

    logic                   rst_meta_r;
    logic                   rst_n_r;
    fwsr_poll_state_t       state_r;
    logic [FL_ADDR_W-1:0]   addr_r;
    logic [FL_DATA_W-1:0]   wdata_r;
    logic [FL_DATA_W-1:0]   prev_r;
    logic [FL_DATA_W-1:0]   cur_r;
    logic [FL_DATA_W-1:0]   result_r;
    logic                   toggle_mode_r;
    logic                   recheck_r;
    logic                   done_r;
    logic                   fail_r;
    logic                   wait_r;
    logic                   bus_req;
    logic                   bus_done;
    logic [FL_DATA_W-1:0]   bus_rdata;
    logic                   bus_state;
    logic                   idle;
    logic                   start_cmd;
    logic                   write_cmd;
    logic                   settled;

    // reset released through two stages, asserted at once
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    assign idle      = (state_r == P_IDLE);
    assign start_cmd = reg_wr_in && (reg_addr_in == REG_CTRL)
                       && reg_wdata_in[CTRL_START_POS] && idle;
    assign write_cmd = reg_wr_in && (reg_addr_in == REG_CTRL)
                       && reg_wdata_in[CTRL_WRITE_POS] && idle && !start_cmd;

    // address and data registers; frozen while a sequence runs
    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            addr_r  <= ADDR_RST;
            wdata_r <= WDATA_RST;
        end else if (reg_wr_in && idle) begin
            if (reg_addr_in == REG_ADDR) begin
                addr_r <= reg_wdata_in[FL_ADDR_W-1:0];
            end
            if (reg_addr_in == REG_WDATA) begin
                wdata_r <= reg_wdata_in[FL_DATA_W-1:0];
            end
        end
    end

    // one bus request per bus state, a single-cycle pulse, then masked until the cycle is done
    assign bus_state = (state_r == P_WRITE) || (state_r == P_READ_A)
                       || (state_r == P_READ_B) || (state_r == P_FINAL);
    assign bus_req   = bus_state && !wait_r;

    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wait_r <= 1'b0;
        end else if (bus_done) begin
            wait_r <= 1'b0;
        end else if (bus_req) begin
            wait_r <= 1'b1;
        end
    end

    // completion test: toggle bit steady, or polling bit equal to target
    assign settled = toggle_mode_r
        ? (prev_r[TOGGLE_BIT_POS] == cur_r[TOGGLE_BIT_POS])
        : (cur_r[POLL_BIT_POS] == wdata_r[POLL_BIT_POS]);

    // poll sequencer
    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r       <= P_IDLE;
            toggle_mode_r <= 1'b0;
            recheck_r     <= 1'b0;
            prev_r        <= WDATA_RST;
            cur_r         <= WDATA_RST;
        end else begin
            case (state_r)
                P_IDLE: begin
                    if (start_cmd) begin
                        toggle_mode_r <= reg_wdata_in[CTRL_TOGGLE_POS];
                        recheck_r     <= 1'b0;
                        state_r       <= P_READ_A;
                    end else if (write_cmd) begin
                        state_r <= P_WRITE;
                    end
                end
                P_WRITE: begin
                    if (bus_done) begin
                        state_r <= P_IDLE;
                    end
                end
                P_READ_A: begin
                    // every status read goes to the watched address
                    if (bus_done) begin
                        cur_r   <= bus_rdata;
                        state_r <= toggle_mode_r ? P_READ_B : P_EVAL;
                    end
                end
                P_READ_B: begin
                    if (bus_done) begin
                        prev_r  <= cur_r;
                        cur_r   <= bus_rdata;
                        state_r <= P_EVAL;
                    end
                end
                P_EVAL: begin
                    if (settled) begin
                        state_r <= P_FINAL;
                    end else if (recheck_r) begin
                        state_r <= P_IDLE;
                    end else if (cur_r[LIMIT_BIT_POS]) begin
                        // status may have ended just as the flag rose
                        recheck_r <= 1'b1;
                        state_r   <= P_READ_A;
                    end else begin
                        state_r <= P_READ_A;
                    end
                end
                P_FINAL: begin
                    // the settling read may hold stale low bits
                    if (bus_done) begin
                        state_r <= P_IDLE;
                    end
                end
                default: begin
                    state_r <= P_IDLE;
                end
            endcase
        end
    end

    // sticky outcome flags, cleared when a new poll starts
    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            done_r   <= 1'b0;
            fail_r   <= 1'b0;
            result_r <= WDATA_RST;
        end else if (state_r == P_FINAL && bus_done) begin
            done_r   <= 1'b1;
            result_r <= bus_rdata;
        end else if (state_r == P_EVAL && !settled && recheck_r) begin
            done_r <= 1'b1;
            fail_r <= 1'b1;
        end else if (start_cmd) begin
            done_r <= 1'b0;
            fail_r <= 1'b0;
        end
    end

    // register read port, data valid the cycle after the strobe
    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                REG_ADDR:   reg_rdata_out <= REG_DATA_W'(addr_r);
                REG_WDATA:  reg_rdata_out <= REG_DATA_W'(wdata_r);
                REG_RDATA:  reg_rdata_out <= REG_DATA_W'(result_r);
                REG_STATUS: begin
                    reg_rdata_out                <= '0;
                    reg_rdata_out[STAT_BUSY_POS] <= !idle;
                    reg_rdata_out[STAT_DONE_POS] <= done_r;
                    reg_rdata_out[STAT_FAIL_POS] <= fail_r;
                    reg_rdata_out[STAT_RYBY_POS] <= ready_busy_n_in;
                    reg_rdata_out[STAT_MODE_POS] <= toggle_mode_r;
                end
                default:    reg_rdata_out <= '0;
            endcase
        end else begin
            reg_rdata_out <= '0;
        end
    end

    fwsr_bus_cycle u_bus (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_r),
        .req_in    (bus_req),
        .we_in     (state_r == P_WRITE),
        .addr_in   (addr_r),
        .wdata_in  (wdata_r),
        .dq_in     (dq_in),
        .done_out  (bus_done),
        .rdata_out (bus_rdata),
        .pins_out  (flash_out)
    );

    // status reads always target the watched address
    chk_poll_addr: assert property (@(posedge clk_in) disable iff (!rst_n_r)
        ($fell(flash_out.oe_n) && !idle) |-> (flash_out.addr == addr_r))
        else $error("status read issued at a foreign address");

    chk_erase_addr: assert property (@(posedge clk_in) disable iff (!rst_n_r)
        (bus_req && state_r != P_WRITE) |=> (flash_out.addr == addr_r))
        else $error("poll read address differs from watched sector");

    // a good result comes only from the extra read after settling
    chk_final_read: assert property (@(posedge clk_in) disable iff (!rst_n_r)
        $rose(done_r) && !fail_r |-> $past(state_r == P_FINAL))
        else $error("done raised without the final re-read");

    chk_final_data: assert property (@(posedge clk_in) disable iff (!rst_n_r)
        (state_r == P_FINAL && bus_done) |=> (result_r == $past(bus_rdata)))
        else $error("final read data not captured");

    // failure only after a recheck that still did not settle
    chk_poll_recheck: assert property (@(posedge clk_in) disable iff (!rst_n_r)
        ($rose(fail_r) && !toggle_mode_r) |-> $past(recheck_r, 1))
        else $error("polling failure declared without recheck");

    chk_tog_recheck: assert property (@(posedge clk_in) disable iff (!rst_n_r)
        ($rose(fail_r) && toggle_mode_r) |-> $past(recheck_r && !settled))
        else $error("toggle failure declared without recheck");

    // toggle judgement needs two fresh reads back to back
    chk_two_reads: assert property (@(posedge clk_in) disable iff (!rst_n_r)
        (state_r == P_EVAL && toggle_mode_r) |-> $past(state_r == P_READ_B))
        else $error("toggle compared without a second read");

    chk_limit_loop: assert property (@(posedge clk_in) disable iff (!rst_n_r)
        (state_r == P_EVAL && !settled && !recheck_r && cur_r[LIMIT_BIT_POS])
        |=> (recheck_r && state_r == P_READ_A))
        else $error("limit flag did not trigger a recheck");

    chk_write_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_r)
        (!flash_out.dq_oe_n) |-> (state_r == P_WRITE))
        else $error("data bus driven outside a write cycle");

endmodule : fwsr_poller
`default_nettype wire

// file: rtl/fwsr_pkg.sv
/*
 * shared constants and types for the flash status poller:
 * register map, field positions, timing counts, state enums, pin bundle.
 * assumes a 25 MHz system clock and a byte-wide flash bus.
 */
package fwsr_pkg;

    // widths of the flash side and the register port
    localparam int FL_ADDR_W   = 22;
    localparam int FL_DATA_W   = 8;
    localparam int REG_ADDR_W  = 4;
    localparam int REG_DATA_W  = 32;

    // register indices on the software port
    localparam logic [REG_ADDR_W-1:0] REG_CTRL   = 4'h0;
    localparam logic [REG_ADDR_W-1:0] REG_ADDR   = 4'h1;
    localparam logic [REG_ADDR_W-1:0] REG_WDATA  = 4'h2;
    localparam logic [REG_ADDR_W-1:0] REG_STATUS = 4'h3;
    localparam logic [REG_ADDR_W-1:0] REG_RDATA  = 4'h4;

    // control register fields (write-only pulses)
    localparam int CTRL_START_POS  = 0;
    localparam int CTRL_TOGGLE_POS = 1;
    localparam int CTRL_WRITE_POS  = 2;

    // status register fields
    localparam int STAT_BUSY_POS  = 0;
    localparam int STAT_DONE_POS  = 1;
    localparam int STAT_FAIL_POS  = 2;
    localparam int STAT_RYBY_POS  = 3;
    localparam int STAT_MODE_POS  = 4;

    // positions of the status bits inside a flash byte
    localparam int POLL_BIT_POS   = 7;
    localparam int TOGGLE_BIT_POS = 6;
    localparam int LIMIT_BIT_POS  = 5;

    // reset values
    localparam logic [FL_ADDR_W-1:0] ADDR_RST  = 22'h00_0000;
    localparam logic [FL_DATA_W-1:0] WDATA_RST = 8'h00;

    // bus timing, times in ns, counts derived and rounded up
    localparam int CLK_PERIOD_NS = 40;
    localparam int T_ACC_NS      = 90;
    localparam int T_WP_NS       = 50;
    localparam int RD_STROBE_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_STROBE_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CNT_W  = 3;

    // bus cycle engine states
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_SETUP,
        BUS_STROBE,
        BUS_HOLD
    } fwsr_bus_state_t;

    // poll sequencer states
    typedef enum logic [2:0] {
        P_IDLE,
        P_WRITE,
        P_READ_A,
        P_READ_B,
        P_EVAL,
        P_FINAL
    } fwsr_poll_state_t;

    // flash-facing outputs; dq_oe_n low while the host drives dq
    typedef struct packed {
        logic                 ce_n;
        logic                 we_n;
        logic                 oe_n;
        logic [FL_ADDR_W-1:0] addr;
        logic [FL_DATA_W-1:0] dq;
        logic                 dq_oe_n;
    } fwsr_pins_t;

endpackage : fwsr_pkg

// file: rtl/fwsr_bus_cycle.sv
/*
 * one flash bus cycle, read or write, chip select framed.
 * assumes requests arrive only while idle and dq_in is synchronous.
 */
`timescale 1ns/1ns
`default_nettype none
module fwsr_bus_cycle (
    input  wire logic                           clk_in,
    input  wire logic                           rst_n_in,
    input  wire logic                           req_in,
    input  wire logic                           we_in,
    input  wire logic [fwsr_pkg::FL_ADDR_W-1:0] addr_in,
    input  wire logic [fwsr_pkg::FL_DATA_W-1:0] wdata_in,
    input  wire logic [fwsr_pkg::FL_DATA_W-1:0] dq_in,
    output logic                                done_out,
    output logic [fwsr_pkg::FL_DATA_W-1:0]      rdata_out,
    output fwsr_pkg::fwsr_pins_t                pins_out
);
    import fwsr_pkg::*;

    fwsr_bus_state_t          state_r;
    logic [STROBE_CNT_W-1:0]  cnt_r;
    logic                     we_r;
    fwsr_pins_t               pins_r;

    // cycle sequence: select, strobe, release
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r        <= BUS_IDLE;
            cnt_r          <= '0;
            we_r           <= 1'b0;
            pins_r.ce_n    <= 1'b1;
            pins_r.we_n    <= 1'b1;
            pins_r.oe_n    <= 1'b1;
            pins_r.addr    <= ADDR_RST;
            pins_r.dq      <= WDATA_RST;
            pins_r.dq_oe_n <= 1'b1;
            rdata_out      <= WDATA_RST;
        end else begin
            case (state_r)
                BUS_IDLE: begin
                    if (req_in) begin
                        pins_r.ce_n    <= 1'b0;
                        pins_r.addr    <= addr_in;
                        pins_r.dq      <= wdata_in;
                        pins_r.dq_oe_n <= ~we_in;
                        we_r           <= we_in;
                        state_r        <= BUS_SETUP;
                    end
                end
                BUS_SETUP: begin
                    // address settles a cycle before any strobe
                    pins_r.oe_n <= we_r;
                    pins_r.we_n <= ~we_r;
                    cnt_r       <= we_r ? STROBE_CNT_W'(WR_STROBE_CYC - 1)
                                        : STROBE_CNT_W'(RD_STROBE_CYC - 1);
                    state_r     <= BUS_STROBE;
                end
                BUS_STROBE: begin
                    if (cnt_r == '0) begin
                        pins_r.oe_n <= 1'b1;
                        pins_r.we_n <= 1'b1;
                        if (!we_r) begin
                            rdata_out <= dq_in;
                        end
                        state_r <= BUS_HOLD;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                BUS_HOLD: begin
                    // data held past the strobe edge, then released
                    pins_r.ce_n    <= 1'b1;
                    pins_r.dq_oe_n <= 1'b1;
                    state_r        <= BUS_IDLE;
                end
                default: begin
                    state_r <= BUS_IDLE;
                end
            endcase
        end
    end

    assign done_out = (state_r == BUS_HOLD);
    assign pins_out = pins_r;

    // both strobes low would be a bus fight inside the flash
    chk_strobe_excl: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !(!pins_r.oe_n && !pins_r.we_n))
        else $error("output and write strobes low together");

endmodule : fwsr_bus_cycle
`default_nettype wire

// file: dv/fwsr_flash_model.sv
/*
 * behavioural flash die for the status poller bench: one program or
 * erase at a time, status bits on the data bus while busy.
 * assumes the poller's pins change just after rising edges of clk_in.
 */
`timescale 1ns/1ns
`default_nettype none
module fwsr_flash_model #(
    parameter int BUSY_CYC       = 40,
    parameter int PROT_PROG_CYC  = 25,
    parameter int PROT_ERASE_CYC = 2500
) (
    input  wire logic                 clk_in,
    input  wire fwsr_pkg::fwsr_pins_t pins_in,
    output logic [7:0]                dq_out,
    output logic                      ready_busy_n_out
);
    import fwsr_pkg::*;
    logic [7:0] array_r   = 8'hFF;
    logic [7:0] prog_r    = 8'h00;
    logic [7:0] last_r    = 8'h00;
    logic       prev_we_r = 1'b1;
    logic       prev_oe_r = 1'b1;
    logic       tog_r     = 1'b0;
    logic       erase_r   = 1'b0;
    logic       limit_r   = 1'b0;
    logic       prot_r    = 1'b0;
    logic       sec_tog_r = 1'b0;
    int         busy_cnt_r = 0;
    logic       busy;
    logic [7:0] stat;

    // a failed operation stays busy until the reset command
    assign busy = (busy_cnt_r != 0) || limit_r;
    // open drain with pull-up, so ready reads high
    assign ready_busy_n_out = busy ? 1'b0 : 1'b1;
    assign stat = {erase_r ? 1'b0 : ~prog_r[7], tog_r, limit_r, 2'b00, sec_tog_r, 2'b00};
    // released bus shows the inverse of the last byte, never a stale copy
    assign dq_out = (!pins_in.ce_n && !pins_in.oe_n) ? (busy ? stat : array_r)
                                                     : ~last_r;

    // strobe edges, toggle flips and the busy countdown
    always_ff @(posedge clk_in) begin
        prev_we_r <= pins_in.we_n;
        prev_oe_r <= pins_in.oe_n;
        if (!pins_in.ce_n && !pins_in.oe_n) begin
            last_r <= dq_out;
        end
        if (!prev_oe_r && pins_in.oe_n && busy) begin
            // suspend is not modelled: toggling simply stops when busy ends
            tog_r <= ~tog_r;
        end
        if (!prev_oe_r && pins_in.oe_n && busy && erase_r) begin
            sec_tog_r <= ~sec_tog_r;
        end
        if (busy_cnt_r > 1) begin
            busy_cnt_r <= busy_cnt_r - 1;
        end else if (busy_cnt_r == 1) begin
            busy_cnt_r <= 0;
            if (!prot_r) begin
                array_r <= erase_r ? 8'hFF : prog_r;
            end
        end
        // write data taken at the rising write strobe
        if (!prev_we_r && pins_in.we_n && !pins_in.ce_n) begin
            if (limit_r) begin
                if (pins_in.dq == 8'hF0) begin
                    limit_r <= 1'b0;
                end
            end else if (!busy) begin
                erase_r <= (pins_in.dq == 8'h30);
                prog_r  <= pins_in.dq;
                if (pins_in.addr[21]) begin
                    limit_r <= 1'b1;
                end else if (pins_in.addr[20]) begin
                    // protected sector: shorter status window for a program, longer one for an erase, array untouched
                    prot_r     <= 1'b1;
                    busy_cnt_r <= (pins_in.dq == 8'h30) ? PROT_ERASE_CYC
                                                        : PROT_PROG_CYC;
                end else begin
                    prot_r     <= 1'b0;
                    busy_cnt_r <= BUSY_CYC;
                end
            end
        end
    end
endmodule : fwsr_flash_model
`default_nettype wire

// file: dv/testbench.sv
/*
 * self-checking bench for the flash status poller with a flash model.
 * assumes the register port answers reads one cycle after the strobe.
 */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import fwsr_pkg::*;
    logic                  clk_in       = 1'b0;
    logic                  arst_n_in    = 1'b0;
    logic                  reg_wr_in    = 1'b0;
    logic                  reg_rd_in    = 1'b0;
    logic [REG_ADDR_W-1:0] reg_addr_in  = '0;
    logic [REG_DATA_W-1:0] reg_wdata_in = '0;
    logic [REG_DATA_W-1:0] reg_rdata_out;
    logic [FL_DATA_W-1:0]  dq_in;
    logic                  ready_busy_n_in;
    fwsr_pins_t            flash_out;
    int                    err_count    = 0;
    int                    num_checks   = 0;
    logic [7:0]            arr_exp      = 8'hFF;

    fwsr_poller u_dut (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .dq_in(dq_in),
        .ready_busy_n_in(ready_busy_n_in), .flash_out(flash_out)
    );
    fwsr_flash_model #(.BUSY_CYC(40)) u_flash (
        .clk_in(clk_in), .pins_in(flash_out), .dq_out(dq_in),
        .ready_busy_n_out(ready_busy_n_in)
    );

    // 25 MHz clock
    initial begin
        forever #20 clk_in = ~clk_in;
    end

    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge clk_in);
        reg_wr_in    <= 1'b0;
    endtask : reg_wr

    // data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clk_in);
        reg_rd_in   <= 1'b0;
        #1 d = reg_rdata_out;
    endtask : reg_rd

    // done with ready high, or done and fail with the flash still busy
    function automatic logic [31:0] exp_status(input logic fail);
        return fail ? 32'h0000_0006 : 32'h0000_000A;
    endfunction : exp_status

    // protected sector keeps its old contents
    function automatic logic [7:0] exp_byte(input logic [7:0] cmd, input logic [21:0] a,
                                            input logic [7:0] old);
        if (a[20]) begin
            return old;
        end
        return (cmd == 8'h30) ? 8'hFF : cmd;
    endfunction : exp_byte

    // one write cycle to the flash, then a poll in the chosen mode
    task automatic run_op(input logic [21:0] a, input logic [7:0] cmd,
                          input logic [7:0] pollv, input logic tog);
        logic [31:0] d;
        int          n;
        reg_wr(REG_ADDR, {10'h000, a});
        reg_wr(REG_WDATA, {24'h00_0000, cmd});
        reg_wr(REG_CTRL, 32'h0000_0004);
        repeat (12) @(posedge clk_in);
        reg_rd(REG_STATUS, d);
        check(d & 32'h0000_0008, 32'h0000_0000, "ready busy not low");
        reg_wr(REG_WDATA, {24'h00_0000, pollv});
        reg_wr(REG_CTRL, {30'h0000_0000, tog, 1'b1});
        reg_rd(REG_STATUS, d);
        check(d & 32'h0000_0001, 32'h0000_0001, "poll not busy");
        n = 0;
        while (d[0] !== 1'b0 && n < 2000) begin
            reg_rd(REG_STATUS, d);
            n++;
        end
        check(d & 32'h0000_000F, exp_status(a[21]), "status at end");
        if (!a[21]) begin
            arr_exp = exp_byte(cmd, a, arr_exp);
            reg_rd(REG_RDATA, d);
            check(d, {24'h00_0000, arr_exp}, "final byte");
        end else begin
            reg_wr(REG_WDATA, 32'h0000_00F0);
            reg_wr(REG_CTRL, 32'h0000_0004);
            repeat (12) @(posedge clk_in);
            reg_rd(REG_STATUS, d);
            check(d & 32'h0000_0008, 32'h0000_0008, "ready not back");
        end
    endtask : run_op

    // main sequence: corner cases per mode, then random programs
    initial begin
        logic [31:0] d;
        logic [7:0]  v;
        void'($urandom(32'hea30f7cb));
        repeat (16) @(posedge clk_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        reg_rd(4'hF, d);
        check(d, 32'h0000_0000, "unmapped read");
        for (int m = 0; m < 2; m++) begin
            run_op(22'h00_0100, 8'h00, 8'h00, m[0]);
            run_op(22'h00_0140, 8'hFF, 8'hFF, m[0]);
            run_op(22'h00_0200, 8'h30, 8'hFF, m[0]);
            run_op(22'h20_0000, 8'h5A, 8'h5A, m[0]);
        end
        run_op(22'h10_0300, 8'h12, 8'h12, 1'b1);
        run_op(22'h10_0400, 8'h30, 8'hFF, 1'b1);
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom);
            if (v == 8'h30) begin
                v = 8'h31;
            end
            run_op(22'($urandom) & 22'h0F_FFFF, v, v, i[0]);
        end
        results();
    end

    // watchdog well beyond the expected run length
    initial begin
        #(40 * 60000);
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        results();
    end
endmodule : testbench
`default_nettype wire
